// ===== design/sbst_tap.sv
// Notes on behaviour
// RL1: The instruction register holds the identification instruction after reset and in test-logic-reset.
// RL2: Identification selects load the fixed id value at capture-DR and shift it in shift-DR.
// RL3: The identification instruction leaves memory data drivers untouched.
// RL4: Bypass loads a zero into the one-bit bypass register at capture-DR and shifts it in shift-DR.
// RL5: Bypass leaves memory data drivers untouched.
// RL6: Sample captures every ring signal into the boundary register and shifts it in shift-DR.
// RL7: Sample leaves memory data drivers untouched.
// RL8: High-impedance sample captures and shifts the ring exactly as plain sample does.
// RL9: High-impedance sample forces every memory data driver off.
// RL10: Reads started under high-impedance sample drive nothing and are flagged as failed.
// RL11: The controller has sixteen states and moves only on a rising test clock, steered by TMS.
// RL12: Power-up reset or five rising edges with TMS high bring the controller to test-logic-reset.
// RL13: TDI is taken only in shift-IR or shift-DR.
// RL14: TDO is driven only in shift-IR or shift-DR and released otherwise.
// RL15: States, instruction capture and update-IR transfer follow the customary scan controller.
// RL16: Opcodes are parameters and any undefined code selects the bypass register.
`timescale 1ns/100ps
`include "sbst_consts.svh"

module sbst_tap #(
    parameter logic [`SBST_IR_LEN-1:0] P_OP_ID       = `SBST_OP_ID,
    parameter logic [`SBST_IR_LEN-1:0] P_OP_SAMPLE   = `SBST_OP_SAMPLE,
    parameter logic [`SBST_IR_LEN-1:0] P_OP_SAMPLE_Z = `SBST_OP_SAMPLE_Z,
    parameter logic [`SBST_IR_LEN-1:0] P_OP_BYPASS   = `SBST_OP_BYPASS,
    // Arbitrary value
    parameter logic [`SBST_ID_LEN-1:0] P_ID_VALUE    = `SBST_ID_VALUE
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rstn,
    input  wire logic                     i_tck,
    input  wire logic                     i_tms,
    input  wire logic                     i_tdi,
    input  wire logic [`SBST_BSR_LEN-1:0] i_ring,
    input  wire logic                     i_mem_dq_oe,
    input  wire logic                     i_mem_rd,
    output logic                          o_tdo,
    output logic                          o_tdo_oe,
    output logic                          o_dq_oe,
    output logic                          o_rd_fail
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    sbst_pin_if pins ();

    sbst_sync u_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_tck  (i_tck),
        .i_tms  (i_tms),
        .i_tdi  (i_tdi),
        .i_ring (i_ring),
        .pins   (pins.src)
    );

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    sbst_pkg::sbst_tap_state_type state_reg;
    sbst_pkg::sbst_dr_sel_type    dr_sel;
    logic [`SBST_IR_LEN-1:0]      ir_reg;
    logic [`SBST_IR_LEN-1:0]      ir_shift_reg;
    logic [`SBST_ID_LEN-1:0]      id_shift_reg;
    logic                         bypass_reg;
    logic [`SBST_BSR_LEN-1:0]     ring_shift_reg;
    logic                         tdo_reg;
    logic                         tdo_oe_reg;
    logic                         rd_fail_reg;
    logic                         hiz_sel;
    logic                         in_shift;

    // ------------------------------------------------------------
    // Controller transition
    // ------------------------------------------------------------
    // RL11 sixteen-state walk
    // RL15 customary state sequence
    function automatic sbst_pkg::sbst_tap_state_type tap_next(
        input sbst_pkg::sbst_tap_state_type s,
        input logic                         tms
    );
        sbst_pkg::sbst_tap_state_type n;
        n = s;
        unique case (s)
            sbst_pkg::ST_RESET:    n = tms ? sbst_pkg::ST_RESET   : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_IDLE:     n = tms ? sbst_pkg::ST_SEL_DR  : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_DR:   n = tms ? sbst_pkg::ST_SEL_IR  : sbst_pkg::ST_CAP_DR;
            sbst_pkg::ST_CAP_DR:   n = tms ? sbst_pkg::ST_EXIT1_DR : sbst_pkg::ST_SHIFT_DR;
            sbst_pkg::ST_SHIFT_DR: n = tms ? sbst_pkg::ST_EXIT1_DR : sbst_pkg::ST_SHIFT_DR;
            sbst_pkg::ST_EXIT1_DR: n = tms ? sbst_pkg::ST_UPD_DR  : sbst_pkg::ST_PAUSE_DR;
            sbst_pkg::ST_PAUSE_DR: n = tms ? sbst_pkg::ST_EXIT2_DR : sbst_pkg::ST_PAUSE_DR;
            sbst_pkg::ST_EXIT2_DR: n = tms ? sbst_pkg::ST_UPD_DR  : sbst_pkg::ST_SHIFT_DR;
            sbst_pkg::ST_UPD_DR:   n = tms ? sbst_pkg::ST_SEL_DR  : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_IR:   n = tms ? sbst_pkg::ST_RESET   : sbst_pkg::ST_CAP_IR;
            sbst_pkg::ST_CAP_IR:   n = tms ? sbst_pkg::ST_EXIT1_IR : sbst_pkg::ST_SHIFT_IR;
            sbst_pkg::ST_SHIFT_IR: n = tms ? sbst_pkg::ST_EXIT1_IR : sbst_pkg::ST_SHIFT_IR;
            sbst_pkg::ST_EXIT1_IR: n = tms ? sbst_pkg::ST_UPD_IR  : sbst_pkg::ST_PAUSE_IR;
            sbst_pkg::ST_PAUSE_IR: n = tms ? sbst_pkg::ST_EXIT2_IR : sbst_pkg::ST_PAUSE_IR;
            sbst_pkg::ST_EXIT2_IR: n = tms ? sbst_pkg::ST_UPD_IR  : sbst_pkg::ST_SHIFT_IR;
            sbst_pkg::ST_UPD_IR:   n = tms ? sbst_pkg::ST_SEL_DR  : sbst_pkg::ST_IDLE;
        endcase
        return n;
    endfunction

    // RL12 power-up entry, TMS walk
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= sbst_pkg::ST_RESET;
        end else if (pins.tck_rise) begin
            state_reg <= tap_next(state_reg, pins.tms);
        end
    end

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    // RL16 unknown codes to bypass
    function automatic sbst_pkg::sbst_dr_sel_type dr_decode(input logic [`SBST_IR_LEN-1:0] code);
        sbst_pkg::sbst_dr_sel_type d;
        d = sbst_pkg::DR_BYPASS;
        if (code == P_OP_ID) begin
            d = sbst_pkg::DR_ID;
        end else if (code == P_OP_SAMPLE || code == P_OP_SAMPLE_Z) begin
            d = sbst_pkg::DR_RING;
        end
        return d;
    endfunction

    assign dr_sel   = dr_decode(ir_reg);
    assign hiz_sel  = (ir_reg == P_OP_SAMPLE_Z);
    assign in_shift = (state_reg == sbst_pkg::ST_SHIFT_IR) || (state_reg == sbst_pkg::ST_SHIFT_DR);

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    // RL1 default instruction
    // RL15 transfer on the falling edge in update-IR
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ir_reg <= P_OP_ID;
        end else if (state_reg == sbst_pkg::ST_RESET) begin
            ir_reg <= P_OP_ID;
        end else if (pins.tck_fall && state_reg == sbst_pkg::ST_UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // RL13 TDI only while shifting
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ir_shift_reg <= `SBST_IR_CAPTURE;
        end else if (pins.tck_rise && state_reg == sbst_pkg::ST_CAP_IR) begin
            ir_shift_reg <= `SBST_IR_CAPTURE;
        end else if (pins.tck_rise && state_reg == sbst_pkg::ST_SHIFT_IR) begin
            ir_shift_reg <= {pins.tdi, ir_shift_reg[`SBST_IR_LEN-1:1]};
        end
    end

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    // RL2 id capture and shift
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            id_shift_reg <= '0;
        end else if (pins.tck_rise && dr_sel == sbst_pkg::DR_ID) begin
            if (state_reg == sbst_pkg::ST_CAP_DR) begin
                id_shift_reg <= P_ID_VALUE;
            end else if (state_reg == sbst_pkg::ST_SHIFT_DR) begin
                id_shift_reg <= {pins.tdi, id_shift_reg[`SBST_ID_LEN-1:1]};
            end
        end
    end

    // RL4 bypass zero capture
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bypass_reg <= `SBST_BYPASS_CAPTURE;
        end else if (pins.tck_rise && dr_sel == sbst_pkg::DR_BYPASS) begin
            if (state_reg == sbst_pkg::ST_CAP_DR) begin
                bypass_reg <= `SBST_BYPASS_CAPTURE;
            end else if (state_reg == sbst_pkg::ST_SHIFT_DR) begin
                bypass_reg <= pins.tdi;
            end
        end
    end

    // RL6 ring capture and shift
    // RL8 same path for high-impedance sample
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ring_shift_reg <= '0;
        end else if (pins.tck_rise && dr_sel == sbst_pkg::DR_RING) begin
            if (state_reg == sbst_pkg::ST_CAP_DR) begin
                ring_shift_reg <= pins.ring;
            end else if (state_reg == sbst_pkg::ST_SHIFT_DR) begin
                ring_shift_reg <= {pins.tdi, ring_shift_reg[`SBST_BSR_LEN-1:1]};
            end
        end
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    // Updated on the falling edge so the controller samples a settled bit
    // RL14 drive only in shift states
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tdo_reg    <= 1'h0;
            tdo_oe_reg <= 1'h0;
        end else if (pins.tck_fall) begin
            tdo_oe_reg <= in_shift;
            if (state_reg == sbst_pkg::ST_SHIFT_IR) begin
                tdo_reg <= ir_shift_reg[0];
            end else if (state_reg == sbst_pkg::ST_SHIFT_DR) begin
                unique case (dr_sel)
                    sbst_pkg::DR_ID:     tdo_reg <= id_shift_reg[0];
                    sbst_pkg::DR_RING:   tdo_reg <= ring_shift_reg[0];
                    default:             tdo_reg <= bypass_reg;
                endcase
            end
        end
    end

    assign o_tdo    = tdo_reg;
    assign o_tdo_oe = tdo_oe_reg;

    // ------------------------------------------------------------
    // Memory side
    // ------------------------------------------------------------
    // RL3 pass-through for other instructions
    // RL5 bypass leaves drivers
    // RL7 sample leaves drivers
    // RL9 drivers forced off
    // Combinational so the gate follows the instruction at once
    assign o_dq_oe = i_mem_dq_oe & ~hiz_sel;

    // RL10 read flagged as failed
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_fail_reg <= 1'h0;
        end else begin
            rd_fail_reg <= i_mem_rd & hiz_sel;
        end
    end

    assign o_rd_fail = rd_fail_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [2:0] ones_cnt_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ones_cnt_reg <= 3'h0;
        end else if (pins.tck_rise) begin
            if (!pins.tms) begin
                ones_cnt_reg <= 3'h0;
            end else if (ones_cnt_reg != `SBST_RESET_ONES) begin
                ones_cnt_reg <= ones_cnt_reg + 3'h1;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_cap_dr;
        pins.tck_rise && state_reg == sbst_pkg::ST_CAP_DR;
    endsequence

    sequence s_upd_ir;
        pins.tck_fall && state_reg == sbst_pkg::ST_UPD_IR;
    endsequence

    chk_ir_default_id: assert property (state_reg == sbst_pkg::ST_RESET |=> ir_reg == P_OP_ID) // RL1
        else $error("instruction not identification in reset state");
    chk_id_capture: assert property (s_cap_dr ##0 dr_sel == sbst_pkg::DR_ID |=> id_shift_reg == P_ID_VALUE) // RL2
        else $error("identification value not captured");
    chk_bypass_zero: assert property (s_cap_dr ##0 dr_sel == sbst_pkg::DR_BYPASS |=> bypass_reg == 1'h0) // RL4
        else $error("bypass capture not zero");
    chk_ring_capture: assert property (s_cap_dr ##0 dr_sel == sbst_pkg::DR_RING // RL6
        |=> ring_shift_reg == $past(pins.ring))
        else $error("ring state not captured");
    chk_hiz_dq_off: assert property (hiz_sel && i_mem_dq_oe |-> !o_dq_oe) // RL9
        else $error("data driver enabled under high-impedance sample");
    chk_dq_passthru: assert property (!hiz_sel |-> o_dq_oe == i_mem_dq_oe) // RL3
        else $error("data driver disturbed by test instruction");
    chk_rd_fail: assert property (hiz_sel && i_mem_rd |=> o_rd_fail) // RL10
        else $error("read under high-impedance sample not failed");
    chk_tms_five_ones: assert property (ones_cnt_reg == `SBST_RESET_ONES |-> state_reg == sbst_pkg::ST_RESET) // RL12
        else $error("five TMS ones did not reach reset state");
    chk_state_on_edge: assert property (!pins.tck_rise |=> $stable(state_reg)) // RL11
        else $error("state moved without a rising test clock");
    chk_tdo_released: assert property (pins.tck_fall && !in_shift |=> !o_tdo_oe) // RL14
        else $error("TDO driven outside shift states");
    chk_tdo_driven: assert property (pins.tck_fall && in_shift |=> o_tdo_oe) // RL14
        else $error("TDO not driven in shift states");
    chk_ir_update: assert property (s_upd_ir |=> ir_reg == $past(ir_shift_reg)) // RL15
        else $error("instruction not transferred in update-IR");

endmodule

// ===== shared/sbst_consts.svh
`ifndef SBST_CONSTS_SVH
`define SBST_CONSTS_SVH

// ----------------------------------------------------------------
// Register lengths
// ----------------------------------------------------------------
`define SBST_IR_LEN         3
`define SBST_ID_LEN         32
`define SBST_BSR_LEN        51

// ----------------------------------------------------------------
// Default instruction codes, replaceable by parameter
// ----------------------------------------------------------------
`define SBST_OP_ID          3'h1
`define SBST_OP_SAMPLE      3'h2
`define SBST_OP_SAMPLE_Z    3'h3
`define SBST_OP_BYPASS      3'h7

// ----------------------------------------------------------------
// Capture and reset values
// ----------------------------------------------------------------
`define SBST_IR_CAPTURE     3'h1
`define SBST_BYPASS_CAPTURE 1'h0
// Arbitrary identification value; bit 0 must stay set
`define SBST_ID_VALUE       32'h5A5A_0001
`define SBST_RESET_ONES     3'h5

`endif

// ===== shared/sbst_pkg.sv
package sbst_pkg;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPD_IR
    } sbst_tap_state_type;

    // ------------------------------------------------------------
    // Data register selected by the instruction
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DR_ID,
        DR_BYPASS,
        DR_RING
    } sbst_dr_sel_type;

endpackage

// ===== shared/sbst_pin_if.sv
`timescale 1ns/100ps
`include "sbst_consts.svh"

// ----------------------------------------------------------------
// Synchronised test pins
// ----------------------------------------------------------------
interface sbst_pin_if;
    logic                     tck_rise;
    logic                     tck_fall;
    logic                     tms;
    logic                     tdi;
    logic [`SBST_BSR_LEN-1:0] ring;

    modport src (output tck_rise, output tck_fall, output tms, output tdi, output ring);
    modport dst (input tck_rise, input tck_fall, input tms, input tdi, input ring);
endinterface

// ===== design/sbst_sync.sv
`timescale 1ns/100ps
`include "sbst_consts.svh"

module sbst_sync (
    input  wire logic                     i_clk,
    input  wire logic                     i_rstn,
    input  wire logic                     i_tck,
    input  wire logic                     i_tms,
    input  wire logic                     i_tdi,
    input  wire logic [`SBST_BSR_LEN-1:0] i_ring,
    sbst_pin_if.src                       pins
);

    // ------------------------------------------------------------
    // Two-stage synchronisers
    // ------------------------------------------------------------
    // Same depth on every pin keeps TMS and TDI aligned to the edge
    logic [2:0]               tck_s1_reg;
    logic [2:0]               tck_s2_reg;
    logic                     tck_s3_reg;
    logic [`SBST_BSR_LEN-1:0] ring_s1_reg;
    logic [`SBST_BSR_LEN-1:0] ring_s2_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tck_s1_reg <= 3'h0;
            tck_s2_reg <= 3'h0;
        end else begin
            tck_s1_reg <= {i_tdi, i_tms, i_tck};
            tck_s2_reg <= tck_s1_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tck_s3_reg <= 1'h0;
        end else begin
            tck_s3_reg <= tck_s2_reg[0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ring_s1_reg <= '0;
            ring_s2_reg <= '0;
        end else begin
            ring_s1_reg <= i_ring;
            ring_s2_reg <= ring_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Edge detection on the settled copy
    // ------------------------------------------------------------
    assign pins.tck_rise = tck_s2_reg[0] & ~tck_s3_reg;
    assign pins.tck_fall = ~tck_s2_reg[0] & tck_s3_reg;
    assign pins.tms      = tck_s2_reg[1];
    assign pins.tdi      = tck_s2_reg[2];
    assign pins.ring     = ring_s2_reg;

endmodule

// ===== sim/sbst_ctrl_model.sv
`timescale 1ns/100ps

module sbst_ctrl_model (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe
);
    // ------------------------------------------------------------
    // Link driver
    // ------------------------------------------------------------
    int  oe_errors;
    real stretch;

    initial begin
        o_tck     = 1'h0;
        o_tms     = 1'h1;
        o_tdi     = 1'h0;
        oe_errors = 0;
        stretch   = 0.0;
    end

    // one rise per step
    // Clock stands still between calls; stretch slows the low phase
    task automatic step(input logic tms, input logic tdi, input logic shifting, output logic tdo);
        o_tms <= tms;
        o_tdi <= shifting ? tdi : ~o_tdi;
        #(62.5 + stretch);
        o_tck = 1'h1;
        tdo   = i_tdo;
        if (i_tdo_oe !== shifting) begin
            oe_errors++;
        end
        #62.5;
        o_tck = 1'h0;
    endtask

    task automatic scan(input logic is_ir, input int len, input logic [63:0] din, output logic [63:0] dout);
        logic d;
        dout = 64'h0;
        step(1'h1, 1'h0, 1'h0, d);
        if (is_ir) begin
            step(1'h1, 1'h0, 1'h0, d);
        end
        step(1'h0, 1'h0, 1'h0, d);
        step(1'h0, 1'h0, 1'h0, d);
        for (int i = 0; i < len; i++) begin
            step(i == len - 1, din[i], 1'h1, d);
            dout[i] = d;
        end
        step(1'h1, 1'h0, 1'h0, d);
        step(1'h0, 1'h0, 1'h0, d);
    endtask
endmodule

// ===== sim/sram_boundary_scan_tap_tb_top.sv
`timescale 1ns/100ps
`include "sbst_consts.svh"

module sram_boundary_scan_tap_tb_top;
    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    typedef struct {
        logic [`SBST_IR_LEN-1:0]  code;
        int                       len;
        logic [63:0]              exp;
        logic [`SBST_BSR_LEN-1:0] ring;
        logic                     dq;
    } sbst_row_type;

    localparam logic [`SBST_BSR_LEN-1:0] RING_A = 51'h5_A3C9_0F1E_2D4B;
    localparam logic [`SBST_BSR_LEN-1:0] RING_B = 51'h2_5C36_F0E1_D2B4;
    localparam int                       LIMIT  = 20000;

    logic                     clk;
    logic                     rstn;
    logic                     tck;
    logic                     tms;
    logic                     tdi;
    logic                     tdo;
    logic                     tdo_oe;
    logic [`SBST_BSR_LEN-1:0] ring;
    logic                     mem_dq_oe;
    logic                     mem_rd;
    logic                     dq_oe;
    logic                     rd_fail;
    int                       failures;
    int                       num_checks;
    int                       cycles;
    sbst_row_type             rows [8];

    sbst_tap i_dut (
        .i_clk       (clk),
        .i_rstn      (rstn),
        .i_tck       (tck),
        .i_tms       (tms),
        .i_tdi       (tdi),
        .i_ring      (ring),
        .i_mem_dq_oe (mem_dq_oe),
        .i_mem_rd    (mem_rd),
        .o_tdo       (tdo),
        .o_tdo_oe    (tdo_oe),
        .o_dq_oe     (dq_oe),
        .o_rd_fail   (rd_fail)
    );

    sbst_ctrl_model i_partner (
        .o_tck    (tck),
        .o_tms    (tms),
        .o_tdi    (tdi),
        .i_tdo    (tdo),
        .i_tdo_oe (tdo_oe)
    );

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic load_ir(input logic [`SBST_IR_LEN-1:0] code);
        logic [63:0] seen;
        i_partner.scan(1'h1, `SBST_IR_LEN, 64'(code), seen);
        check("instruction capture", seen, 64'(`SBST_IR_CAPTURE));
    endtask

    task automatic read_pulse(input logic exp);
        @(posedge clk);
        mem_rd    <= 1'h1;
        mem_dq_oe <= 1'h0;
        #1;
        check("data driver idle", 64'(dq_oe), 64'h0);
        @(posedge clk);
        mem_rd    <= 1'h0;
        mem_dq_oe <= 1'h1;
        #1;
        check("read fail pulse", 64'(rd_fail), 64'(exp));
        @(posedge clk);
        #1;
        check("read fail end", 64'(rd_fail), 64'h0);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [63:0] seen;
        logic        d;
        clk        = 1'h0;
        rstn       = 1'h0;
        ring       = '0;
        mem_dq_oe  = 1'h1;
        mem_rd     = 1'h0;
        failures   = 0;
        num_checks = 0;
        cycles     = 0;
        // Undefined codes fall back to the one-bit bypass path
        rows[0] = '{`SBST_OP_ID, 32, 64'(`SBST_ID_VALUE), RING_A, 1'h1};
        rows[1] = '{`SBST_OP_BYPASS, 2, 64'h2, RING_A, 1'h1};
        rows[2] = '{`SBST_OP_SAMPLE, 51, 64'(RING_A), RING_A, 1'h1};
        rows[3] = '{`SBST_OP_SAMPLE_Z, 51, 64'(RING_B), RING_B, 1'h0};
        rows[4] = '{3'h0, 2, 64'h2, RING_B, 1'h1};
        rows[5] = '{3'h4, 2, 64'h2, RING_B, 1'h1};
        rows[6] = '{3'h5, 2, 64'h2, RING_B, 1'h1};
        rows[7] = '{3'h6, 2, 64'h2, RING_B, 1'h1};
        repeat (11) @(posedge clk);
        #1;
        check("tdo enable in reset", 64'(tdo_oe), 64'h0);
        @(posedge clk);
        rstn <= 1'h1;
        repeat (4) @(posedge clk);
        i_partner.step(1'h0, 1'h0, 1'h0, d);
        i_partner.scan(1'h0, 32, '1, seen);
        check("id after power up", seen, 64'(`SBST_ID_VALUE));
        for (int r = 0; r < 8; r++) begin
            @(posedge clk);
            ring <= rows[r].ring;
            i_partner.stretch = (r == 2) ? 500.0 : 0.0;
            load_ir(rows[r].code);
            i_partner.scan(1'h0, rows[r].len, '1, seen);
            check("data register", seen, rows[r].exp);
            check("data driver enable", 64'(dq_oe), 64'(rows[r].dq));
            read_pulse(~rows[r].dq);
        end
        // Four ones from shift-DR must not reset; the fifth must
        load_ir(`SBST_OP_SAMPLE_Z);
        i_partner.step(1'h1, 1'h0, 1'h0, d);
        i_partner.step(1'h0, 1'h0, 1'h0, d);
        i_partner.step(1'h0, 1'h0, 1'h0, d);
        i_partner.step(1'h1, 1'h1, 1'h1, d);
        repeat (3) i_partner.step(1'h1, 1'h0, 1'h0, d);
        check("no reset after four", 64'(dq_oe), 64'h0);
        i_partner.step(1'h1, 1'h0, 1'h0, d);
        check("reset after five", 64'(dq_oe), 64'h1);
        i_partner.step(1'h0, 1'h0, 1'h0, d);
        // Power-up reset in mid-run while drivers are forced off
        load_ir(`SBST_OP_SAMPLE_Z);
        @(posedge clk);
        rstn <= 1'h0;
        #1;
        check("enable in reset", 64'(dq_oe), 64'h1);
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        repeat (4) @(posedge clk);
        i_partner.step(1'h0, 1'h0, 1'h0, d);
        i_partner.scan(1'h0, 32, '1, seen);
        check("id after reset", seen, 64'(`SBST_ID_VALUE));
        check("tdo enable errors", 64'(i_partner.oe_errors), 64'h0);
        give_verdict();
    end
endmodule
